// ### aisc_pkg.sv
// Shared constants and carrier types of the self-clocked converter readout.
`default_nettype none
package aisc_pkg;
    // ***************************************************************
    // Timing
    // ***************************************************************
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
    localparam int unsigned POR_TIME_US = 1000;
    localparam int unsigned POR_CYC = POR_TIME_US * CLK_MHZ;
    localparam int unsigned SAMPLE_HZ = 76_800;
    localparam int unsigned SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
    localparam int unsigned EXT_OSC_PER_SAMPLE = 2;
    localparam int unsigned SCK_HALF_CYC = 8;
    localparam int unsigned CONV_SAMPLES = 64;

    // ***************************************************************
    // Frame and buffer
    // ***************************************************************
    localparam int unsigned FRAME_BITS = 32;
    localparam int unsigned BUF_DEPTH = 2;
    localparam logic EOC_DONE = 1'h0;
    localparam logic EOC_BUSY = 1'h1;

    // ***************************************************************
    // Types
    // ***************************************************************
    typedef enum logic [2:0] {
        ST_POR = 3'h0,
        ST_CONV = 3'h1,
        ST_SLEEP = 3'h2,
        ST_HIGH = 3'h3,
        ST_LOW = 3'h4
    } aisc_state_e;

    typedef struct packed {
        logic sck;
        logic sck_oe_n;
        logic sdo;
        logic pullup_en;
    } aisc_pin_s;

    typedef struct packed {
        logic valid;
        logic [FRAME_BITS-1:0] data;
    } aisc_rx_s;

    localparam aisc_pin_s PIN_POR = '{sck: 1'h1, sck_oe_n: 1'h1, sdo: 1'h1, pullup_en: 1'h1};
endpackage : aisc_pkg
`default_nettype wire

// ### aisc_readout.sv
// Self-clocked continuous readout of the converter serial port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Clock mode chosen once at reset end
// - Reset ends about 1 ms after start
// - Weak pull-up on clock pin during reset
// - Clock pin low at reset end: external
// - Converting: clock and data held high
// - Done: clock and data driven low
// - Sleep at least half clock period
// - Frame is exactly 32 rising edges
// - Sample data input on every rise
// - Change data output on falling edges
// - Drive own shift clock onto pin
// - After frame: data high, clock high
// - Internal sampling at 76800 Hz
// - External oscillator: two cycles per sample
// - Load result when done flag falls
module aisc_readout
    import aisc_pkg::*;
#(
    parameter int unsigned POR_CYCLES = POR_CYC,
    parameter int unsigned SCK_HALF = SCK_HALF_CYC,
    parameter int unsigned N_SAMPLES = CONV_SAMPLES
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic osc_clk_in,
    input wire logic ext_osc_sel_in,
    input wire logic sck_in,
    input wire logic sdi_in,
    input wire logic [FRAME_BITS-2:0] conv_data_in,
    input wire logic rx_ready_in,
    output var aisc_pin_s pin_out,
    output var aisc_rx_s rx_out,
    output logic ext_mode_out
);
    localparam int PW = $clog2(POR_CYCLES + 1);
    localparam int SW = $clog2(SAMPLE_CYC + 1);
    localparam int NW = $clog2(N_SAMPLES + 1);
    localparam int HW = $clog2(SCK_HALF + 1);
    localparam int BW = $clog2(FRAME_BITS + 1);
    localparam int DW = $clog2(EXT_OSC_PER_SAMPLE + 1);

    // ***************************************************************
    // Parameter checks
    // ***************************************************************
    if (SCK_HALF < 3) begin : g_bad_half
        $error("SCK_HALF must be at least 3 for the input synchroniser");
    end
    if (POR_CYCLES < 2 || N_SAMPLES < 1) begin : g_bad_cnt
        $error("POR_CYCLES must be at least 2 and N_SAMPLES at least 1");
    end

    // ***************************************************************
    // State types
    // ***************************************************************
    typedef struct packed {
        aisc_state_e st;
        logic [PW-1:0] por_cnt;
        logic ext_mode;
        logic [SW-1:0] tick_cnt;
        logic [NW-1:0] samp_cnt;
        logic [HW-1:0] ph_cnt;
        logic [BW-1:0] bit_cnt;
        logic [FRAME_BITS-1:0] tx_sr;
        logic [FRAME_BITS-1:0] rx_sr;
        logic [FRAME_BITS-1:0] buf0;
        logic [FRAME_BITS-1:0] buf1;
        logic [1:0] buf_cnt;
        logic rx_valid;
        aisc_pin_s pin;
        logic [1:0] sck_sync;
        logic [1:0] sdi_sync;
        logic [1:0] sel_sync;
        logic [2:0] osc_sync;
    } aisc_sys_s;

    typedef struct packed {
        logic [1:0] rst_sync;
        logic [DW-1:0] div;
        logic tgl;
    } aisc_osc_s;

    localparam aisc_sys_s SYS_RST = '{st: ST_POR, pin: PIN_POR, default: '0};

    aisc_sys_s r;
    aisc_sys_s n;
    aisc_osc_s ro;
    aisc_osc_s no;

    // ***************************************************************
    // Oscillator domain: one event toggle per sampling period
    // ***************************************************************
    // Two oscillator cycles make one sampling period
    always_comb begin
        no = ro;
        no.rst_sync = {ro.rst_sync[0], reset_in};
        if (ro.rst_sync[1]) begin
            no.div = '0;
            no.tgl = 1'h0;
        end else if (ro.div == DW'(EXT_OSC_PER_SAMPLE - 1)) begin
            no.div = '0;
            no.tgl = ~ro.tgl;
        end else begin
            no.div = ro.div + DW'(1);
        end
    end

    // Oscillator domain registers
    always_ff @(posedge osc_clk_in) begin
        ro <= no;
    end

    // ***************************************************************
    // System domain: reset, conversion timing, frame
    // ***************************************************************
    // Next state of the whole readout
    always_comb begin
        logic samp_tick;
        logic pop;
        logic [1:0] cnt;
        logic [FRAME_BITS-1:0] b0;
        logic [FRAME_BITS-1:0] b1;
        logic push;
        samp_tick = 1'h0;
        pop = 1'h0;
        cnt = 2'h0;
        b0 = '0;
        b1 = '0;
        push = 1'h0;
        n = r;
        n.sck_sync = {r.sck_sync[0], sck_in};
        n.sdi_sync = {r.sdi_sync[0], sdi_in};
        n.sel_sync = {r.sel_sync[0], ext_osc_sel_in};
        n.osc_sync = {r.osc_sync[1:0], ro.tgl};
        // Sampling period: internal divider or oscillator event
        if (r.tick_cnt == SW'(SAMPLE_CYC - 1)) begin
            n.tick_cnt = '0;
        end else begin
            n.tick_cnt = r.tick_cnt + SW'(1);
        end
        if (r.sel_sync[1]) begin
            samp_tick = r.osc_sync[2] ^ r.osc_sync[1];
        end else begin
            samp_tick = (r.tick_cnt == SW'(SAMPLE_CYC - 1));
        end
        case (r.st)
            ST_POR: begin
                n.pin = PIN_POR;
                n.por_cnt = r.por_cnt + PW'(1);
                if (r.por_cnt == PW'(POR_CYCLES - 1)) begin
                    n.ext_mode = ~r.sck_sync[1];
                    n.st = ST_CONV;
                    n.samp_cnt = '0;
                    n.pin.pullup_en = 1'h0;
                    n.pin.sck_oe_n = ~r.sck_sync[1];
                end
            end
            ST_CONV: begin
                n.pin.sdo = EOC_BUSY;
                n.pin.sck = 1'h1;
                if (samp_tick) begin
                    n.samp_cnt = r.samp_cnt + NW'(1);
                    if (r.samp_cnt == NW'(N_SAMPLES - 1)) begin
                        n.tx_sr = {EOC_DONE, conv_data_in};
                        n.pin.sdo = EOC_DONE;
                        n.pin.sck = 1'h0;
                        n.ph_cnt = '0;
                        n.st = ST_SLEEP;
                    end
                end
            end
            ST_SLEEP: begin
                // Stay asleep while the buffer has no free entry
                if (r.ph_cnt != HW'(SCK_HALF - 1)) begin
                    n.ph_cnt = r.ph_cnt + HW'(1);
                end else if (!r.ext_mode && r.buf_cnt != 2'(BUF_DEPTH)) begin
                    n.st = ST_HIGH;
                    n.pin.sck = 1'h1;
                    n.bit_cnt = BW'(1);
                    n.rx_sr = {r.rx_sr[FRAME_BITS-2:0], r.sdi_sync[1]};
                    n.ph_cnt = '0;
                end
            end
            ST_HIGH: begin
                n.ph_cnt = r.ph_cnt + HW'(1);
                if (r.ph_cnt == HW'(SCK_HALF - 1)) begin
                    n.ph_cnt = '0;
                    if (r.bit_cnt == BW'(FRAME_BITS)) begin
                        n.st = ST_CONV;
                        n.pin.sdo = EOC_BUSY;
                        n.samp_cnt = '0;
                        push = 1'h1;
                    end else begin
                        n.st = ST_LOW;
                        n.pin.sck = 1'h0;
                        n.pin.sdo = r.tx_sr[FRAME_BITS-2];
                        n.tx_sr = {r.tx_sr[FRAME_BITS-2:0], 1'h0};
                    end
                end
            end
            ST_LOW: begin
                n.ph_cnt = r.ph_cnt + HW'(1);
                if (r.ph_cnt == HW'(SCK_HALF - 1)) begin
                    n.ph_cnt = '0;
                    n.st = ST_HIGH;
                    n.pin.sck = 1'h1;
                    n.bit_cnt = r.bit_cnt + BW'(1);
                    n.rx_sr = {r.rx_sr[FRAME_BITS-2:0], r.sdi_sync[1]};
                end
            end
            default: begin
                n = SYS_RST;
            end
        endcase
        // Two-entry buffer of received input words
        pop = r.rx_valid && rx_ready_in;
        cnt = r.buf_cnt;
        b0 = r.buf0;
        b1 = r.buf1;
        if (pop) begin
            b0 = r.buf1;
            cnt = cnt - 2'h1;
        end
        if (push) begin
            if (cnt == 2'h0) begin
                b0 = r.rx_sr;
            end else begin
                b1 = r.rx_sr;
            end
            cnt = cnt + 2'h1;
        end
        n.buf0 = b0;
        n.buf1 = b1;
        n.buf_cnt = cnt;
        n.rx_valid = (cnt != 2'h0);
    end

    // System domain registers
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            r <= SYS_RST;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from registers
    assign pin_out = r.pin;
    assign rx_out = '{valid: r.rx_valid, data: r.buf0};
    assign ext_mode_out = r.ext_mode;

    // ***************************************************************
    // Checks
    // ***************************************************************
    logic [HW:0] sleep_len_ff;
    logic [BW-1:0] rise_cnt_ff;

    // Cycles spent asleep and clock rises in the frame
    always_ff @(posedge clk_sys_in) begin
        if (reset_in || r.st == ST_CONV) begin
            sleep_len_ff <= '0;
            rise_cnt_ff <= '0;
        end else begin
            if (r.st == ST_SLEEP && sleep_len_ff != '1) begin
                sleep_len_ff <= sleep_len_ff + (HW + 1)'(1);
            end
            if (n.pin.sck && !r.pin.sck) begin
                rise_cnt_ff <= rise_cnt_ff + BW'(1);
            end
        end
    end

    sequence s_conv_end;
        r.st == ST_CONV ##1 r.st == ST_SLEEP;
    endsequence

    sequence s_frame_end;
        r.st == ST_HIGH ##1 r.st == ST_CONV;
    endsequence

    a_mode_held: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        r.st != ST_POR && $past(r.st) != ST_POR |-> $stable(r.ext_mode))
        else $error("clock mode changed after reset");
    a_por_hold: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        r.st == ST_POR && r.por_cnt < PW'(POR_CYCLES - 1) |=> r.st == ST_POR)
        else $error("reset cycle ended early");
    a_por_pullup: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        r.st == ST_POR |-> r.pin.pullup_en && r.pin.sck_oe_n)
        else $error("pull-up off or clock driven during reset");
    a_ext_select: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (r.st == ST_POR && !r.sck_sync[1]) ##1 r.st == ST_CONV |-> r.ext_mode)
        else $error("low clock pin did not select external mode");
    a_conv_busy: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        r.st == ST_CONV |-> r.pin.sdo && r.pin.sck)
        else $error("clock or data low while converting");
    a_done_low: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        s_conv_end |-> !r.pin.sdo && !r.pin.sck)
        else $error("done not shown as low clock and data");
    a_sleep_min: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        r.st == ST_HIGH && $past(r.st) == ST_SLEEP |-> sleep_len_ff >= (HW + 1)'(SCK_HALF))
        else $error("sleep shorter than half a clock period");
    a_frame_len: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        s_frame_end |-> rise_cnt_ff == BW'(FRAME_BITS))
        else $error("frame did not hold 32 rising edges");
    a_sdi_sample: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        $rose(r.pin.sck) && r.st == ST_HIGH |-> r.rx_sr[0] == $past(r.sdi_sync[1]))
        else $error("input bit not taken on rising edge");
    a_sdo_on_fall: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        r.st == ST_LOW && $changed(r.pin.sdo) |-> $fell(r.pin.sck))
        else $error("data changed away from a falling edge");
    a_own_clock: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        r.st != ST_POR && !r.ext_mode |-> !r.pin.sck_oe_n)
        else $error("internal clock not driven onto pin");
    a_tail_high: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        s_frame_end |-> r.pin.sdo ##1 r.pin.sck [*3])
        else $error("data or clock not high after frame");
    a_int_rate: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        r.tick_cnt == SW'(SAMPLE_CYC - 1) |=> r.tick_cnt == '0 ##1 r.tick_cnt == SW'(1))
        else $error("internal sampling divider off");
    a_osc_period: assert property (@(posedge osc_clk_in) disable iff (ro.rst_sync[1])
        ro.div == DW'(EXT_OSC_PER_SAMPLE - 1) |=> ro.tgl != $past(ro.tgl) ##1 $stable(ro.tgl))
        else $error("oscillator event not every two cycles");
    a_load_result: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        s_conv_end |-> r.tx_sr == {EOC_DONE, $past(conv_data_in)})
        else $error("result not loaded when done fell");

    // Sleep ends on time and an unread word stands still
    a_sleep_max: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        r.st == ST_SLEEP && !r.ext_mode && r.buf_cnt != 2'(BUF_DEPTH)
            && sleep_len_ff == (HW + 1)'(SCK_HALF - 1) |=> r.st == ST_HIGH)
        else $error("sleep outlasted half a clock period");
    a_word_held: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        r.rx_valid && !rx_ready_in |=> r.rx_valid && r.buf0 == $past(r.buf0))
        else $error("unread word changed before it was taken");
endmodule : aisc_readout
`default_nettype wire

// ### aisc_ctrl_model.sv
// Behavioural controller that captures converter frames.
`timescale 1ns/100ps
`default_nettype none
module aisc_ctrl_model
    import aisc_pkg::*;
(
    input wire logic clk_sys_in,
    input wire aisc_pin_s pin_in,
    input wire logic hold_low_in,
    input wire logic [FRAME_BITS-1:0] word_in,
    output logic sck_pin_out,
    output logic sdi_out,
    output logic [FRAME_BITS-1:0] cap_out,
    output int frames_out,
    output int viol_out
);
    logic prev_sck = 1'h1;
    logic prev_sdo = 1'h1;
    logic float_lvl = 1'h1;
    int k = 0;
    // ****************
    // Pin level
    // ****************
    // Device driver, controller hold, pull-up, else floating
    always_comb begin
        if (!pin_in.sck_oe_n) sck_pin_out = pin_in.sck;
        else if (hold_low_in) sck_pin_out = 1'h0;
        else if (pin_in.pullup_en) sck_pin_out = 1'h1;
        else sck_pin_out = float_lvl;
    end
    initial begin
        sdi_out = 1'h1;
        cap_out = '0;
        frames_out = 0;
        viol_out = 0;
    end
    // ****************
    // Capture
    // ****************
    // Take bit on rise, present next input bit on fall
    always @(posedge clk_sys_in) begin
        float_lvl <= ~float_lvl;
        prev_sck <= pin_in.sck;
        prev_sdo <= pin_in.sdo;
        if (!pin_in.sck_oe_n && !prev_sck && pin_in.sck) begin
            cap_out <= {cap_out[FRAME_BITS-2:0], pin_in.sdo};
            if (k == FRAME_BITS - 1) begin
                k <= 0;
                frames_out <= frames_out + 1;
            end else begin
                k <= k + 1;
            end
        end else if (!pin_in.sck_oe_n && prev_sck && !pin_in.sck) begin
            sdi_out <= word_in[FRAME_BITS-1-k];
        end else if (k == 0) begin
            sdi_out <= word_in[FRAME_BITS-1];
        end else if (pin_in.sdo != prev_sdo) begin
            viol_out <= viol_out + 1;
        end
    end
endmodule : aisc_ctrl_model
`default_nettype wire

// ### tb_adc_internal_sck_continuous_readout.sv
// Testbench of the self-clocked converter readout.
`timescale 1ns/100ps
`default_nettype none
module tb_adc_internal_sck_continuous_readout
    import aisc_pkg::*;
;
    localparam int POR_T = 20;
    localparam int HALF_T = 8;
    localparam int NS_T = 2;
    logic clk_sys_in = 1'h0;
    logic reset_in = 1'h1;
    logic osc_clk_in = 1'h0;
    logic ext_osc_sel_in = 1'h0;
    logic hold_low = 1'h0;
    logic rx_ready_in = 1'h0;
    logic [FRAME_BITS-2:0] conv_data_in = 31'h2a3c_0f96;
    logic [FRAME_BITS-1:0] w [3] = '{32'hc3a5_1e69, 32'h0f1e_2d3c, 32'h8001_7ffe};
    logic [FRAME_BITS-1:0] word = 32'hc3a5_1e69;
    logic sck_pin;
    logic sdi_pin;
    aisc_pin_s pin_out;
    aisc_rx_s rx_out;
    logic ext_mode_out;
    logic [FRAME_BITS-1:0] cap;
    int frames;
    int viol;
    int bad_count = 0;
    int n_compared = 0;
    // ****************
    // Clocks and instances
    // ****************
    always #10 clk_sys_in = ~clk_sys_in;
    // Oscillator, unrelated phase
    initial begin
        #7;
        forever #24 osc_clk_in = ~osc_clk_in;
    end
    aisc_readout #(.POR_CYCLES(POR_T), .SCK_HALF(HALF_T), .N_SAMPLES(NS_T)) i_dut (
        .clk_sys_in(clk_sys_in), .reset_in(reset_in), .osc_clk_in(osc_clk_in),
        .ext_osc_sel_in(ext_osc_sel_in), .sck_in(sck_pin), .sdi_in(sdi_pin),
        .conv_data_in(conv_data_in), .rx_ready_in(rx_ready_in), .pin_out(pin_out),
        .rx_out(rx_out), .ext_mode_out(ext_mode_out));
    aisc_ctrl_model i_ctrl (.clk_sys_in(clk_sys_in), .pin_in(pin_out), .hold_low_in(hold_low),
        .word_in(word), .sck_pin_out(sck_pin), .sdi_out(sdi_pin), .cap_out(cap),
        .frames_out(frames), .viol_out(viol));
    // ****************
    // Helpers
    // ****************
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    function automatic logic pick(input int sel);
        case (sel)
            0: return pin_out.sdo;
            1: return pin_out.sck;
            default: return rx_out.valid;
        endcase
    endfunction : pick
    task automatic wait_for(input int sel, input logic v, input int bound, output int n);
        n = 0;
        while (pick(sel) !== v) begin
            @(posedge clk_sys_in);
            #1;
            n++;
            if (n > bound) begin
                bad_count++;
                $display("[FAIL] wait %0d expected %h seen timeout", sel, v);
                report_and_stop();
            end
        end
    endtask : wait_for
    task automatic pop(input logic [FRAME_BITS-1:0] exp);
        check("rx valid", 1'h1, rx_out.valid);
        check("rx word", exp, rx_out.data);
        @(posedge clk_sys_in);
        rx_ready_in <= 1'h1;
        @(posedge clk_sys_in);
        rx_ready_in <= 1'h0;
        #1;
    endtask : pop
    // ****************
    // Scenarios
    // ****************
    task automatic do_reset(input logic hold);
        @(posedge clk_sys_in);
        reset_in <= 1'h1;
        hold_low <= hold;
        repeat (9) @(posedge clk_sys_in);
        #1;
        check("reset pins", PIN_POR, pin_out);
        check("reset valid", 1'h0, rx_out.valid);
        @(posedge clk_sys_in);
        reset_in <= 1'h0;
        repeat (POR_T - 3) @(posedge clk_sys_in);
        #1;
        check("pull-up in power-on", 1'h1, pin_out.pullup_en);
        repeat (6) @(posedge clk_sys_in);
        #1;
        check("clock mode", hold, ext_mode_out);
        check("clock pin released", hold, pin_out.sck_oe_n);
        check("pull-up off", 1'h0, pin_out.pullup_en);
        $display("do_reset done");
    endtask : do_reset
    task automatic t_frame();
        int n;
        int bad_sck;
        logic [FRAME_BITS-2:0] sent;
        sent = conv_data_in;
        wait_for(0, 1'h0, 3000, n);
        check("sck at done", 1'h0, pin_out.sck);
        wait_for(1, 1'h1, 40, n);
        check("sleep cycles", HALF_T, n);
        @(posedge clk_sys_in);
        conv_data_in <= 31'h1234_5678;
        #1;
        wait_for(2, 1'h1, 700, n);
        check("bits out", {1'h0, sent}, cap);
        check("sdo after frame", 1'h1, pin_out.sdo);
        check("sck after frame", 1'h1, pin_out.sck);
        word <= w[1];
        n = 0;
        bad_sck = 0;
        while (pin_out.sdo === 1'h1 && n < 2000) begin
            if (pin_out.sck !== 1'h1) bad_sck++;
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        check("sck low in conversion", 0, bad_sck);
        check("conversion time", 1, n >= SAMPLE_CYC * (NS_T - 1) && n <= SAMPLE_CYC * NS_T + 20);
        $display("t_frame done");
    endtask : t_frame
    task automatic t_stall();
        int n;
        int bad;
        n = 0;
        while (frames < 2 && n < 1500) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        check("second frame", 2, frames);
        word <= w[2];
        wait_for(0, 1'h1, 20, n);
        wait_for(0, 1'h0, 3000, n);
        bad = 0;
        repeat (600) begin
            @(posedge clk_sys_in);
            #1;
            if (pin_out.sck !== 1'h0 || pin_out.sdo !== 1'h0) bad++;
        end
        check("stalled asleep", 0, bad);
        pop(w[0]);
        pop(w[1]);
        wait_for(2, 1'h1, 900, n);
        check("third frame out", {1'h0, 31'h1234_5678}, cap);
        pop(w[2]);
        check("sdo steady in phase", 0, viol);
        $display("t_stall done");
    endtask : t_stall
    task automatic t_ext();
        int n;
        @(posedge clk_sys_in);
        ext_osc_sel_in <= 1'h1;
        do_reset(1'h1);
        wait_for(0, 1'h0, 60, n);
        check("oscillator conversion", 1, n >= 2 && n <= 8);
        @(posedge clk_sys_in);
        hold_low <= 1'h0;
        repeat (20) @(posedge clk_sys_in);
        #1;
        check("mode kept", 1'h1, ext_mode_out);
        $display("t_ext done");
    endtask : t_ext
    // ****************
    // Main sequence
    // ****************
    initial begin
        do_reset(1'h0);
        t_frame();
        t_stall();
        t_ext();
        report_and_stop();
    end
endmodule : tb_adc_internal_sck_continuous_readout
`default_nettype wire
